// *** design/aspf_pkg.sv ***
package aspf_pkg;

	// register byte offsets
	localparam logic [11:0] ASPF_OFS_DATA = 12'h000;
	localparam logic [11:0] ASPF_OFS_RSR = 12'h004;
	localparam logic [11:0] ASPF_OFS_FLAG = 12'h018;
	localparam logic [11:0] ASPF_OFS_IBRD = 12'h024;
	localparam logic [11:0] ASPF_OFS_FBRD = 12'h028;
	localparam logic [11:0] ASPF_OFS_LCRH = 12'h02c;
	localparam logic [11:0] ASPF_OFS_CTL = 12'h030;
	localparam logic [11:0] ASPF_OFS_IFLS = 12'h034;
	localparam logic [11:0] ASPF_OFS_IM = 12'h038;
	localparam logic [11:0] ASPF_OFS_RIS = 12'h03c;
	localparam logic [11:0] ASPF_OFS_MIS = 12'h040;
	localparam logic [11:0] ASPF_OFS_ICR = 12'h044;

	// line control field positions
	localparam int ASPF_LC_BRK = 0;
	localparam int ASPF_LC_PEN = 1;
	localparam int ASPF_LC_EPS = 2;
	localparam int ASPF_LC_STP2 = 3;
	localparam int ASPF_LC_FEN = 4;
	localparam int ASPF_LC_WLEN = 5;
	localparam int ASPF_LC_SPS = 7;

	// port control field positions
	localparam int ASPF_CT_EN = 0;
	localparam int ASPF_CT_LBE = 7;
	localparam int ASPF_CT_TXE = 8;
	localparam int ASPF_CT_RXE = 9;

	// flag register field positions
	localparam int ASPF_FR_BUSY = 3;
	localparam int ASPF_FR_RX_FIFO_EMPTY = 4;
	localparam int ASPF_FR_TX_FIFO_FULL = 5;
	localparam int ASPF_FR_RX_FIFO_FULL = 6;
	localparam int ASPF_FR_TX_FIFO_EMPTY = 7;

	// interrupt source bit positions
	localparam int ASPF_IR_RX = 4;
	localparam int ASPF_IR_TX = 5;
	localparam int ASPF_IR_RT = 6;
	localparam int ASPF_IR_FE = 7;
	localparam int ASPF_IR_PE = 8;
	localparam int ASPF_IR_BE = 9;
	localparam int ASPF_IR_OE = 10;

	// reset values
	localparam logic [9:0] ASPF_CTL_RST = 10'h300;
	localparam logic [5:0] ASPF_IFLS_RST = 6'h12;

	// sizes and counts
	localparam logic [4:0] ASPF_DEPTH = 5'h10;
	localparam logic [22:0] ASPF_ACC_STEP = 23'h000040;
	localparam logic [3:0] ASPF_START_TICK = 4'h7;
	localparam logic [3:0] ASPF_BIT_TICK = 4'hf;
	localparam int ASPF_RT_BITS = 32;
	localparam logic [9:0] ASPF_RT_TICKS = 10'(ASPF_RT_BITS * 16);

	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} aspf_txst_t;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} aspf_rxst_t;

	// one receive queue entry
	typedef struct packed {
		logic oe;
		logic be;
		logic pe;
		logic fe;
		logic [7:0] data;
	} aspf_rxent_t;

	// committed divisor and line settings
	typedef struct packed {
		logic [15:0] ibrd;
		logic [5:0] fbrd;
		logic [7:0] lcrh;
	} aspf_cfg_t;

endpackage

// *** design/aspf_uart.sv ***
`timescale 1ns/100ps
module aspf_uart
	import aspf_pkg::*;
(
	input wire logic clk_i, // system clock
	input wire logic rst_b_i, // synchronous reset, active low
	input wire logic [11:0] addr_i, // register byte address
	input wire logic [31:0] wdata_i, // write data
	input wire logic wr_i, // write strobe
	input wire logic rd_i, // read strobe
	output logic [31:0] rdata_o, // read data, cycle after rd_i
	input wire logic serial_rx_in_i, // serial receive line
	output logic serial_tx_out_o, // serial transmit line
	output logic irq_o // combined interrupt request
);

	typedef struct packed {
		logic [15:0] ibrd;
		logic [5:0] fbrd;
		logic [7:0] lcrh_w;
		aspf_cfg_t cfg;
		logic [9:0] ctl;
		logic [5:0] ifls;
		logic [10:0] im;
		logic [10:0] ris;
		logic [3:0] rsr;
		logic [31:0] rdata;
		logic [15:0][7:0] txq;
		logic [3:0] txw;
		logic [3:0] txr;
		logic [4:0] txn;
		aspf_rxent_t [15:0] rxq;
		logic [3:0] rxw;
		logic [3:0] rxr;
		logic [4:0] rxn;
		logic [22:0] acc;
		aspf_txst_t txst;
		logic [3:0] tx_sub;
		logic [2:0] tx_bit;
		logic [7:0] tx_sh;
		logic tx_par;
		logic tx_out;
		logic tx_line;
		aspf_rxst_t rxst;
		logic [3:0] rx_sub;
		logic [2:0] rx_bit;
		logic [7:0] rx_sh;
		logic rx_pe;
		logic rx_pbit;
		logic rx_mark;
		logic rx_ovr;
		logic [9:0] rt_cnt;
	} aspf_state_t;

	aspf_state_t s;
	aspf_state_t next_s;

	// trigger level in entries for a level select code
	function automatic logic [4:0] lvl(input logic [2:0] sel);
		case (sel)
			3'h0: lvl = 5'h02;
			3'h1: lvl = 5'h04;
			3'h2: lvl = 5'h08;
			3'h3: lvl = 5'h0c;
			3'h4: lvl = 5'h0e;
			default: lvl = 5'h08;
		endcase
	endfunction

	// keep only the programmed character length
	function automatic logic [7:0] wmask(input logic [7:0] d, input logic [1:0] wl);
		case (wl)
			2'h0: wmask = d & 8'h1f;
			2'h1: wmask = d & 8'h3f;
			2'h2: wmask = d & 8'h7f;
			default: wmask = d;
		endcase
	endfunction

	// parity bit value for a masked character
	function automatic logic parbit(input logic [7:0] d, input logic [7:0] lc);
		if (lc[ASPF_LC_SPS]) begin
			parbit = ~lc[ASPF_LC_EPS];
		end else begin
			parbit = lc[ASPF_LC_EPS] ? ^d : ~^d;
		end
	endfunction

	logic [7:0] lc;
	logic [21:0] div;
	logic [4:0] dep;
	logic [2:0] last_bit;
	logic tick;
	logic rx_in;
	logic port_en;
	logic busy;
	logic [22:0] acc_sum;
	aspf_rxent_t ent;

	assign lc = s.cfg.lcrh;
	assign div = {s.cfg.ibrd, s.cfg.fbrd};
	assign dep = lc[ASPF_LC_FEN] ? ASPF_DEPTH : 5'h01;
	assign last_bit = 3'(3'h4 + {1'b0, lc[ASPF_LC_WLEN +: 2]});
	assign port_en = s.ctl[ASPF_CT_EN];
	assign rx_in = s.ctl[ASPF_CT_LBE] ? s.tx_line : serial_rx_in_i;
	assign busy = (s.txn != 5'h00) || (s.txst != TX_IDLE);
	// fractional accumulator, one tick per divisor/64 clocks
	assign acc_sum = s.acc + ASPF_ACC_STEP;
	assign tick = (div != 22'h000000) && (acc_sum >= {1'b0, div});

	assign rdata_o = s.rdata;
	assign serial_tx_out_o = s.tx_line;
	assign irq_o = |(s.ris & s.im);

	// next-state logic
	always_comb begin
		next_s = s;
		ent = '0;

		if (tick) begin
			next_s.acc = acc_sum - {1'b0, div};
		end else if (div != 22'h000000) begin
			next_s.acc = acc_sum;
		end

		// register reads; data returned the cycle after the strobe
		if (rd_i) begin
			next_s.rdata = 32'h00000000;
			case (addr_i)
				ASPF_OFS_DATA: begin
					// twelve bits from the receive queue
					next_s.rdata = {20'h00000, s.rxq[s.rxr]};
					if (s.rxn != 5'h00) begin
						next_s.rsr[2:0] = {s.rxq[s.rxr].be, s.rxq[s.rxr].pe, s.rxq[s.rxr].fe};
						next_s.rxr = s.rxr + 4'h1;
						next_s.rxn = s.rxn - 5'h01;
						if (s.rxn == 5'h01) begin
							next_s.ris[ASPF_IR_RT] = 1'b0;
						end
					end
				end
				ASPF_OFS_RSR: next_s.rdata = {28'h0000000, s.rsr};
				ASPF_OFS_FLAG: begin
					next_s.rdata[ASPF_FR_BUSY] = busy;
					next_s.rdata[ASPF_FR_RX_FIFO_EMPTY] = (s.rxn == 5'h00);
					next_s.rdata[ASPF_FR_TX_FIFO_FULL] = (s.txn == dep);
					next_s.rdata[ASPF_FR_RX_FIFO_FULL] = (s.rxn == dep);
					next_s.rdata[ASPF_FR_TX_FIFO_EMPTY] = (s.txn == 5'h00);
				end
				ASPF_OFS_IBRD: next_s.rdata = {16'h0000, s.ibrd};
				ASPF_OFS_FBRD: next_s.rdata = {26'h0000000, s.fbrd};
				ASPF_OFS_LCRH: next_s.rdata = {24'h000000, s.lcrh_w};
				ASPF_OFS_CTL: next_s.rdata = {22'h000000, s.ctl};
				ASPF_OFS_IFLS: next_s.rdata = {26'h0000000, s.ifls};
				ASPF_OFS_IM: next_s.rdata = {21'h000000, s.im};
				ASPF_OFS_RIS: next_s.rdata = {21'h000000, s.ris};
				ASPF_OFS_MIS: next_s.rdata = {21'h000000, s.ris & s.im};
				default: next_s.rdata = 32'h00000000;
			endcase
		end

		// register writes; hardware sets below win over these clears
		if (wr_i) begin
			case (addr_i)
				ASPF_OFS_DATA: begin
					// queue eight bits, dropped when full
					if (s.txn != dep) begin
						next_s.txq[s.txw] = wdata_i[7:0];
						next_s.txw = lc[ASPF_LC_FEN] ? s.txw + 4'h1 : s.txw;
						next_s.txn = s.txn + 5'h01;
					end
				end
				ASPF_OFS_RSR: next_s.rsr = 4'h0;
				ASPF_OFS_IBRD: next_s.ibrd = wdata_i[15:0];
				ASPF_OFS_FBRD: next_s.fbrd = wdata_i[5:0];
				ASPF_OFS_LCRH: begin
					next_s.lcrh_w = wdata_i[7:0];
					next_s.cfg = {s.ibrd, s.fbrd, wdata_i[7:0]};
				end
				ASPF_OFS_CTL: next_s.ctl = wdata_i[9:0];
				ASPF_OFS_IFLS: next_s.ifls = wdata_i[5:0];
				ASPF_OFS_IM: next_s.im = wdata_i[10:0];
				ASPF_OFS_ICR: next_s.ris = s.ris & ~wdata_i[10:0];
				default: ;
			endcase
		end

		// transmitter; once started it runs to the end even if disabled
		case (s.txst)
			TX_IDLE: begin
				next_s.tx_out = 1'b1;
				// start a frame from the queue
				if (port_en && s.ctl[ASPF_CT_TXE] && (s.txn != 5'h00)) begin
					next_s.tx_sh = wmask(s.txq[s.txr], lc[ASPF_LC_WLEN +: 2]);
					next_s.tx_par = parbit(wmask(s.txq[s.txr], lc[ASPF_LC_WLEN +: 2]), lc);
					next_s.txr = lc[ASPF_LC_FEN] ? s.txr + 4'h1 : s.txr;
					next_s.txn = next_s.txn - 5'h01;
					// transmit level reached on the way down
					if (!lc[ASPF_LC_FEN] || (next_s.txn == lvl(s.ifls[2:0]))) begin
						next_s.ris[ASPF_IR_TX] = 1'b1;
					end
					next_s.txst = TX_START;
					next_s.tx_sub = 4'h0;
					next_s.tx_out = 1'b0;
				end
			end
			default: begin
				if (tick) begin
					next_s.tx_sub = s.tx_sub + 4'h1;
					if (s.tx_sub == ASPF_BIT_TICK) begin
						case (s.txst)
							TX_START: begin
								next_s.txst = TX_DATA;
								next_s.tx_bit = 3'h0;
								next_s.tx_out = s.tx_sh[0];
							end
							TX_DATA: begin
								if (s.tx_bit == last_bit) begin
									next_s.tx_bit = 3'h0;
									next_s.txst = lc[ASPF_LC_PEN] ? TX_PAR : TX_STOP;
									next_s.tx_out = lc[ASPF_LC_PEN] ? s.tx_par : 1'b1;
								end else begin
									next_s.tx_bit = s.tx_bit + 3'h1;
									next_s.tx_out = s.tx_sh[s.tx_bit + 3'h1];
								end
							end
							TX_PAR: begin
								next_s.txst = TX_STOP;
								next_s.tx_out = 1'b1;
							end
							TX_STOP: begin
								if (lc[ASPF_LC_STP2] && (s.tx_bit == 3'h0)) begin
									next_s.tx_bit = 3'h1;
								end else begin
									next_s.txst = TX_IDLE;
								end
							end
							default: next_s.txst = TX_IDLE;
						endcase
					end
				end
			end
		endcase
		next_s.tx_line = lc[ASPF_LC_BRK] ? 1'b0 : next_s.tx_out;

		// receiver
		case (s.rxst)
			RX_IDLE: begin
				// wait for marking before a new start
				if (rx_in) begin
					next_s.rx_mark = 1'b1;
				end
				if (s.rx_mark && !rx_in && port_en && s.ctl[ASPF_CT_RXE]) begin
					next_s.rxst = RX_START;
					next_s.rx_sub = 4'h0;
				end
			end
			default: begin
				if (tick) begin
					next_s.rx_sub = s.rx_sub + 4'h1;
					case (s.rxst)
						RX_START: begin
							if (s.rx_sub == ASPF_START_TICK) begin
								next_s.rx_sub = 4'h0;
								next_s.rx_bit = 3'h0;
								next_s.rx_sh = 8'h00;
								next_s.rxst = rx_in ? RX_IDLE : RX_DATA;
							end
						end
						RX_DATA: begin
							if (s.rx_sub == ASPF_BIT_TICK) begin
								next_s.rx_sh[s.rx_bit] = rx_in;
								next_s.rx_bit = s.rx_bit + 3'h1;
								if (s.rx_bit == last_bit) begin
									next_s.rxst = lc[ASPF_LC_PEN] ? RX_PAR : RX_STOP;
								end
							end
						end
						RX_PAR: begin
							if (s.rx_sub == ASPF_BIT_TICK) begin
								next_s.rx_pbit = rx_in;
								next_s.rx_pe = (rx_in != parbit(s.rx_sh, lc));
								next_s.rxst = RX_STOP;
							end
						end
						RX_STOP: begin
							if (s.rx_sub == ASPF_BIT_TICK) begin
								next_s.rxst = RX_IDLE;
								next_s.rx_mark = 1'b0;
								ent.fe = !rx_in;
								ent.pe = lc[ASPF_LC_PEN] && s.rx_pe;
								// whole character low is a break
								ent.be = !rx_in && (s.rx_sh == 8'h00) && !(lc[ASPF_LC_PEN] && s.rx_pbit);
								ent.data = ent.be ? 8'h00 : s.rx_sh;
								ent.oe = s.rx_ovr;
								next_s.ris[ASPF_IR_FE] = next_s.ris[ASPF_IR_FE] | ent.fe;
								next_s.ris[ASPF_IR_PE] = next_s.ris[ASPF_IR_PE] | ent.pe;
								next_s.ris[ASPF_IR_BE] = next_s.ris[ASPF_IR_BE] | ent.be;
								if (next_s.rxn == dep) begin
									next_s.rsr[3] = 1'b1;
									next_s.rx_ovr = 1'b1;
									next_s.ris[ASPF_IR_OE] = 1'b1;
								end else begin
									next_s.rxq[s.rxw] = ent;
									next_s.rxw = lc[ASPF_LC_FEN] ? s.rxw + 4'h1 : s.rxw;
									next_s.rxn = next_s.rxn + 5'h01;
									next_s.rx_ovr = 1'b0;
									next_s.rt_cnt = 10'h000;
									if (!lc[ASPF_LC_FEN] || (next_s.rxn == lvl(s.ifls[5:3]))) begin
										next_s.ris[ASPF_IR_RX] = 1'b1;
									end
								end
							end
						end
						default: next_s.rxst = RX_IDLE;
					endcase
				end
			end
		endcase
		// in single-entry mode both pointers stay on one entry, the read pointer held on the write pointer
		if (!lc[ASPF_LC_FEN]) begin
			next_s.rxr = s.rxw;
		end

		// idle timer while data waits, stops once it fires
		if (next_s.rxn == 5'h00) begin
			next_s.rt_cnt = 10'h000;
		end else if (tick && (s.rt_cnt != ASPF_RT_TICKS) && (next_s.rt_cnt == s.rt_cnt)) begin
			next_s.rt_cnt = s.rt_cnt + 10'h001;
			if (s.rt_cnt == ASPF_RT_TICKS - 10'h001) begin
				next_s.ris[ASPF_IR_RT] = 1'b1;
			end
		end
	end

	// state register
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			s <= '0;
			s.ctl <= ASPF_CTL_RST;
			s.ifls <= ASPF_IFLS_RST;
			s.tx_out <= 1'b1;
			s.tx_line <= 1'b1;
			s.txst <= TX_IDLE;
			s.rxst <= RX_IDLE;
		end else begin
			s <= next_s;
		end
	end

endmodule // aspf_uart

// *** verification/aspf_far.sv ***
`timescale 1ns/100ps
module aspf_far #(
	parameter int BIT_CLKS = 16
) (
	input wire logic clk_i, // system clock
	input wire logic serial_tx_out_i, // line from the port
	output logic serial_rx_in_o // line into the port, idles high
);
	logic [7:0] got;
	logic [7:0] got_q[$];
	initial serial_rx_in_o = 1'b1;
	always begin
		@(negedge serial_tx_out_i);
		repeat (BIT_CLKS / 2) @(posedge clk_i);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CLKS) @(posedge clk_i);
			got[i] = serial_tx_out_i;
		end
		repeat (BIT_CLKS) @(posedge clk_i);
		// a frame without a high stop is not kept
		if (serial_tx_out_i === 1'b1) got_q.push_back(got);
	end
	// start, lsb first, chosen stop level
	task automatic send(input logic [7:0] d, input logic stop);
		logic [9:0] fr;
		fr = {stop, d, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge clk_i);
			serial_rx_in_o <= fr[i];
			repeat (BIT_CLKS - 1) @(posedge clk_i);
		end
		@(posedge clk_i);
		serial_rx_in_o <= 1'b1;
	endtask
	// start, eight data, given parity bit, high stop
	task automatic send_par(input logic [7:0] d, input logic p);
		logic [10:0] fr;
		fr = {1'b1, p, d, 1'b0};
		for (int i = 0; i < 11; i++) begin
			@(posedge clk_i);
			serial_rx_in_o <= fr[i];
			repeat (BIT_CLKS - 1) @(posedge clk_i);
		end
	endtask
	// line low for n clocks: glitch or break
	task automatic hold_low(input int n);
		@(posedge clk_i);
		serial_rx_in_o <= 1'b0;
		repeat (n) @(posedge clk_i);
		serial_rx_in_o <= 1'b1;
	endtask
endmodule // aspf_far

// *** verification/aspf_uart_monitor.sv ***
`timescale 1ns/100ps
module aspf_uart_monitor
	import aspf_pkg::*;
(
	input wire logic clk_i, // system clock
	input wire logic rst_b_i, // reset, active low
	input wire logic [11:0] addr_i, // register address
	input wire logic [31:0] wdata_i, // write data
	input wire logic wr_i, // write strobe
	input wire logic rd_i, // read strobe
	input wire logic [31:0] rdata_o, // read data
	input wire logic serial_rx_in_i, // receive line
	input wire logic serial_tx_out_o, // transmit line
	input wire logic irq_o // interrupt request
);
	logic [15:0] ibrd;
	logic [5:0] fbrd;
	logic [21:0] div;
	logic brk;
	logic [10:0] mask;
	// shadows of software writes; divisor only counts once committed
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			ibrd <= 16'h0000;
			fbrd <= 6'h00;
			div <= 22'h000000;
			brk <= 1'b0;
			mask <= 11'h000;
		end else if (wr_i) begin
			if (addr_i == ASPF_OFS_IBRD) ibrd <= wdata_i[15:0];
			if (addr_i == ASPF_OFS_FBRD) fbrd <= wdata_i[5:0];
			if (addr_i == ASPF_OFS_IM) mask <= wdata_i[10:0];
			if (addr_i == ASPF_OFS_LCRH) div <= {ibrd, fbrd};
			if (addr_i == ASPF_OFS_LCRH) brk <= wdata_i[ASPF_LC_BRK];
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	property p_reset_state;
		disable iff (1'b0) !rst_b_i |=> serial_tx_out_o && !irq_o && rdata_o == 32'h0;
	endproperty
	a_reset_state: assert property (p_reset_state) else $error("outputs off reset values");
	property p_read_hold;
		!rd_i |=> $stable(rdata_o);
	endproperty
	a_read_hold: assert property (p_read_hold) else $error("read data moved without a read");
	property p_unmapped;
		rd_i && addr_i == 12'h008 |=> rdata_o == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_mask_gate;
		mask[10:4] == 7'h00 |-> !irq_o;
	endproperty
	a_mask_gate: assert property (p_mask_gate) else $error("request with all masked");
	property p_masked_view;
		rd_i && addr_i == ASPF_OFS_MIS && mask[10:4] == 7'h00 |=> rdata_o == 32'h0;
	endproperty
	a_masked_view: assert property (p_masked_view) else $error("masked view not zero");
	property p_busy;
		rd_i && addr_i == ASPF_OFS_FLAG ##1 !rdata_o[ASPF_FR_TX_FIFO_EMPTY] |-> rdata_o[ASPF_FR_BUSY];
	endproperty
	a_busy: assert property (p_busy) else $error("queue holds data but not busy");
	property p_flag_excl;
		rd_i && addr_i == ASPF_OFS_FLAG |=> !(rdata_o[ASPF_FR_RX_FIFO_EMPTY] && rdata_o[ASPF_FR_RX_FIFO_FULL])
			&& !(rdata_o[ASPF_FR_TX_FIFO_EMPTY] && rdata_o[ASPF_FR_TX_FIFO_FULL]);
	endproperty
	a_flag_excl: assert property (p_flag_excl) else $error("empty and full together");
	property p_err_clear;
		wr_i && addr_i == ASPF_OFS_RSR ##2 rd_i && addr_i == ASPF_OFS_RSR |=> rdata_o[3:0] == 4'h0;
	endproperty
	a_err_clear: assert property (p_err_clear) else $error("error flags survive clear");
	property p_break_low;
		brk && $past(brk) && $past(brk, 2) |-> !serial_tx_out_o;
	endproperty
	a_break_low: assert property (p_break_low) else $error("line high during break send");
	property p_start_len;
		$fell(serial_tx_out_o) && div == 22'h000040 |-> ##15 !serial_tx_out_o;
	endproperty
	a_start_len: assert property (p_start_len) else $error("start bit short");
endmodule // aspf_uart_monitor

bind aspf_uart aspf_uart_monitor mon (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i),
	.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .serial_rx_in_i(serial_rx_in_i),
	.serial_tx_out_o(serial_tx_out_o), .irq_o(irq_o));

// *** verification/tb.sv ***
`timescale 1ns/100ps
module tb;
	import aspf_pkg::*;
	logic clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic [11:0] addr_i = 12'h000;
	logic [31:0] wdata_i = 32'h0;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [31:0] rdata_o;
	logic serial_rx_in_i;
	logic serial_tx_out_o;
	logic irq_o;
	logic [31:0] rv;
	int n_fail = 0;
	int n_checks = 0;
	int cycles = 0;
	always #5 clk_i = ~clk_i;
	aspf_uart dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
		.rd_i(rd_i), .rdata_o(rdata_o), .serial_rx_in_i(serial_rx_in_i), .serial_tx_out_o(serial_tx_out_o),
		.irq_o(irq_o));
	aspf_far far (.clk_i(clk_i), .serial_tx_out_i(serial_tx_out_o), .serial_rx_in_o(serial_rx_in_i));
	task automatic close_out();
		if (n_fail == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask
	// read data appears in the cycle after the strobe and holds until the next read
	task automatic rd(input logic [11:0] a);
		@(posedge clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 rv = rdata_o;
	endtask
	// bounded poll, so a stuck flag cannot hang the run
	task automatic wait_flag(input int b, input logic v);
		for (int i = 0; i < 500; i++) begin
			rd(ASPF_OFS_FLAG);
			if (rv[b] === v) return;
		end
		chk({31'h0, rv[b]}, {31'h0, v});
	endtask
	task automatic t_reset();
		rd(ASPF_OFS_CTL);
		chk(rv, 32'h300);
		rd(ASPF_OFS_IFLS);
		chk(rv, 32'h12);
		rd(ASPF_OFS_FLAG);
		chk(rv, 32'h90);
		rd(12'h008);
		chk(rv, 32'h0);
	endtask
	// holding register only: second byte is lost, first kept
	task automatic t_overrun();
		far.send(8'h11, 1'b1);
		far.send(8'h22, 1'b1);
		wait_flag(ASPF_FR_RX_FIFO_EMPTY, 1'b0);
		rd(ASPF_OFS_DATA);
		chk(rv, 32'h011);
		rd(ASPF_OFS_RSR);
		chk(rv, 32'h8);
		wr(ASPF_OFS_RSR, 32'h0);
	endtask
	task automatic t_tx();
		wr(ASPF_OFS_DATA, 32'ha5);
		wr(ASPF_OFS_DATA, 32'h3c);
		rd(ASPF_OFS_FLAG);
		chk(rv & 32'h88, 32'h08);
		wait_flag(ASPF_FR_BUSY, 1'b0);
		chk({24'h0, far.got_q.pop_front()}, 32'ha5);
		chk({24'h0, far.got_q.pop_front()}, 32'h3c);
		// disable right after the frame starts
		wr(ASPF_OFS_DATA, 32'h42);
		wr(ASPF_OFS_CTL, 32'h300);
		wait_flag(ASPF_FR_BUSY, 1'b0);
		chk({24'h0, far.got_q.pop_front()}, 32'h42);
	endtask
	task automatic t_divisor();
		wr(ASPF_OFS_CTL, 32'h301);
		wr(ASPF_OFS_IBRD, 32'h2);
		wr(ASPF_OFS_DATA, 32'h96);
		wait_flag(ASPF_FR_BUSY, 1'b0);
		chk({24'h0, far.got_q.pop_front()}, 32'h96);
		wr(ASPF_OFS_IBRD, 32'h1);
		wr(ASPF_OFS_LCRH, 32'h70);
	endtask
	task automatic t_rx();
		far.send(8'h5a, 1'b1);
		wait_flag(ASPF_FR_RX_FIFO_EMPTY, 1'b0);
		rd(ASPF_OFS_DATA);
		// overrun left pending earlier marks this next character
		chk(rv, 32'h85a);
		far.send(8'hc3, 1'b0);
		wait_flag(ASPF_FR_RX_FIFO_EMPTY, 1'b0);
		rd(ASPF_OFS_DATA);
		chk(rv, 32'h1c3);
		rd(ASPF_OFS_RSR);
		chk(rv, 32'h1);
		wr(ASPF_OFS_RSR, 32'h0);
		rd(ASPF_OFS_RSR);
		chk(rv, 32'h0);
		far.hold_low(4);
		// long enough that a wrongly accepted start would have landed
		repeat (200) @(posedge clk_i);
		rd(ASPF_OFS_FLAG);
		chk(rv & 32'h10, 32'h10);
	endtask
	task automatic t_break_rx();
		far.hold_low(400);
		wait_flag(ASPF_FR_RX_FIFO_EMPTY, 1'b0);
		rd(ASPF_OFS_DATA);
		chk(rv, 32'h500);
		rd(ASPF_OFS_FLAG);
		chk(rv & 32'h10, 32'h10);
		wr(ASPF_OFS_RSR, 32'h0);
	endtask
	task automatic t_timeout();
		wr(ASPF_OFS_ICR, 32'h7f0);
		far.send(8'h33, 1'b1);
		wait_flag(ASPF_FR_RX_FIFO_EMPTY, 1'b0);
		repeat (600) @(posedge clk_i);
		rd(ASPF_OFS_RIS);
		chk(rv & 32'h40, 32'h40);
		chk({31'h0, irq_o}, 32'h0);
		rd(ASPF_OFS_MIS);
		chk(rv, 32'h0);
		wr(ASPF_OFS_IM, 32'h40);
		#1 chk({31'h0, irq_o}, 32'h1);
		rd(ASPF_OFS_MIS);
		chk(rv, 32'h40);
		wr(ASPF_OFS_ICR, 32'h40);
		#1 chk({31'h0, irq_o}, 32'h0);
		rd(ASPF_OFS_DATA);
		chk(rv, 32'h033);
	endtask
	task automatic t_brk_loop();
		wr(ASPF_OFS_LCRH, 32'h71);
		repeat (50) @(posedge clk_i);
		chk({31'h0, serial_tx_out_o}, 32'h0);
		wr(ASPF_OFS_LCRH, 32'h70);
		repeat (3) @(posedge clk_i);
		chk({31'h0, serial_tx_out_o}, 32'h1);
		repeat (200) @(posedge clk_i);
		far.got_q.delete();
		wr(ASPF_OFS_CTL, 32'h381);
		wr(ASPF_OFS_DATA, 32'h81);
		wait_flag(ASPF_FR_RX_FIFO_EMPTY, 1'b0);
		rd(ASPF_OFS_DATA);
		chk(rv, 32'h081);
	endtask
	// parity check on receive, then a seven-bit even-parity two-stop frame sampled here
	task automatic t_parity();
		wr(ASPF_OFS_LCRH, 32'h76);
		far.send_par(8'h5a, 1'b1);
		wait_flag(ASPF_FR_RX_FIFO_EMPTY, 1'b0);
		rd(ASPF_OFS_DATA);
		chk(rv, 32'h25a);
		far.send_par(8'h5b, 1'b1);
		wait_flag(ASPF_FR_RX_FIFO_EMPTY, 1'b0);
		rd(ASPF_OFS_DATA);
		chk(rv, 32'h05b);
		// queue two while stopped, so the first start follows the enable
		wr(ASPF_OFS_CTL, 32'h300);
		wr(ASPF_OFS_LCRH, 32'h5e);
		wr(ASPF_OFS_DATA, 32'h5b);
		wr(ASPF_OFS_DATA, 32'h5b);
		wr(ASPF_OFS_CTL, 32'h301);
		@(negedge serial_tx_out_o);
		// mid parity bit, after seven data bits
		repeat (136) @(posedge clk_i);
		chk({31'h0, serial_tx_out_o}, 32'h1);
		// mid second stop; one stop would show the next start here
		repeat (32) @(posedge clk_i);
		chk({31'h0, serial_tx_out_o}, 32'h1);
		wait_flag(ASPF_FR_BUSY, 1'b0);
		wr(ASPF_OFS_RSR, 32'h0);
		wr(ASPF_OFS_LCRH, 32'h70);
	endtask
	initial begin
		repeat (3) @(posedge clk_i);
		rst_b_i <= 1'b1;
		t_reset();
		wr(ASPF_OFS_IBRD, 32'h1);
		wr(ASPF_OFS_LCRH, 32'h60);
		wr(ASPF_OFS_CTL, 32'h301);
		t_overrun();
		wr(ASPF_OFS_LCRH, 32'h70);
		t_tx();
		t_divisor();
		t_rx();
		t_break_rx();
		t_parity();
		t_timeout();
		t_brk_loop();
		close_out();
	end
	// cut a hang short
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_fail++;
			close_out();
		end
	end
endmodule // tb
